/* File: crf_core.sv */
// Purpose: programmer-visible register file of an 8-bit cpu with operand addressing
// Assumes: driven by decode and execution logic on pclk; apb for debug access
// Notes: one packed state struct, filled in one comb process, registered in one ff
//
// Behaviour
// - primary set holds acc, flags, three pairs; alternate set swaps only wholesale.
// - special registers: vector page, fetch counter, two index, stack pointer, pc.
// - sign flag takes the result's most significant bit.
// - zero flag set when result is zero, else cleared.
// - half carry flag captures carry or borrow out of low nibble.
// - logical operations set parity flag when result has even ones.
// - arithmetic sets overflow flag when signed byte or word range is exceeded.
// - subtract flag set by subtraction, cleared by addition.
// - carry flag takes carry or borrow out of msb; shifts also update it.
// - vector page supplies high byte of interrupt vector table address.
// - reset clears vector page, fetch counter, stack pointer and pc.
// - low seven fetch counter bits increment on every opcode fetch.
// - pc holds next instruction address and advances after every fetch.
// - 3-bit byte select decodes b,c,d,e,h,l,a; code 110 selects nothing.
// - acc-pair and index-x word selects decode with high and low halves.
// - stack-pointer and index-y word selects decode as documented.
// - register indirect address comes from bc, de or hl.
// - indexed address is index plus sign-extended 8-bit displacement.
// - extended address and immediates come from instruction bytes.
// - relative target is pc plus instruction displacement.
// - i/o strobe asserted; operand form puts immediate low, acc high.
// - register pair i/o form puts b low and c high.
// - internal i/o forms put immediate or c low and zero high.
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps

module crf_core
    import crf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // fetch and exchange
    input wire logic opcode_fetch_indicator,
    input wire logic [15:0] fetch_step,
    input wire logic exchange_sets,
    // byte read and write ports
    input wire logic [2:0] byte_rd_sel,
    output logic [7:0] byte_rd_data,
    input wire logic byte_wr_en,
    input wire logic [2:0] byte_wr_sel,
    input wire logic [7:0] byte_wr_data,
    // word read and write ports
    input wire crf_wsel_e word_kind,
    input wire logic [1:0] word_rd_sel,
    output logic [15:0] word_rd_data,
    output logic [7:0] word_rd_high,
    output logic [7:0] word_rd_low,
    input wire logic word_wr_en,
    input wire logic [1:0] word_wr_sel,
    input wire logic [15:0] word_wr_data,
    // alu result for flag update
    input wire logic flag_upd,
    input wire crf_alu_s alu,
    input wire logic [7:0] alu_op_a,
    input wire logic [7:0] alu_op_b,
    input wire logic [7:0] alu_op_a_hi,
    input wire logic [7:0] alu_op_b_hi,
    // operand addressing
    input wire crf_amode_e amode,
    input wire logic [1:0] indirect_sel,
    input wire logic use_second_index,
    input wire logic [7:0] instr_byte0,
    input wire logic [7:0] instr_byte1,
    input wire logic word_immediate,
    output logic [15:0] operand_addr,
    output logic [15:0] immediate_data,
    input wire logic pc_load,
    // i/o addressing
    input wire logic io_req,
    input wire crf_iofm_e io_form,
    output logic [15:0] io_addr,
    output logic io_space_strobe_n,
    // interrupt vector
    input wire logic [7:0] vector_low,
    output logic [15:0] vector_table_addr,
    // observation
    output logic [7:0] flags_now
);

    crf_state_s st;
    crf_state_s next_st;
    logic apb_wr;
    logic apb_rd;
    logic [7:0] res8;
    logic res_sign;
    logic [15:0] disp_ext;
    logic [15:0] idx;

    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !penable && !pwrite;
    assign pready = 1'b1;  // no wait states: every access completes in the access phase
    assign pslverr = 1'b0;

    // result byte and sign used by flag logic; word ops look at the high byte
    assign res8 = alu.word_op ? alu.sum[15:8] : alu.sum[7:0];
    assign res_sign = res8[7];
    assign disp_ext = {{8{instr_byte0[7]}}, instr_byte0};
    assign idx = use_second_index ? st.second_index : st.first_index;

    // byte read decode from the primary set
    always_comb
    begin
        case (byte_rd_sel)
            CRF_SEL_B: byte_rd_data = st.primary_register_set.bc[15:8];
            CRF_SEL_C: byte_rd_data = st.primary_register_set.bc[7:0];
            CRF_SEL_D: byte_rd_data = st.primary_register_set.de[15:8];
            CRF_SEL_E: byte_rd_data = st.primary_register_set.de[7:0];
            CRF_SEL_H: byte_rd_data = st.primary_register_set.hl[15:8];
            CRF_SEL_L: byte_rd_data = st.primary_register_set.hl[7:0];
            CRF_SEL_A: byte_rd_data = st.primary_register_set.acc;
            default: byte_rd_data = 8'h00;  // code 110 names no register
        endcase
    end

    // word read decode, four field flavours share codes 00 and 01
    always_comb
    begin
        case (word_rd_sel)
            2'h0: word_rd_data = st.primary_register_set.bc;
            2'h1: word_rd_data = st.primary_register_set.de;
            2'h2:
            begin
                case (word_kind)
                    CRF_WS_INDEX_X: word_rd_data = st.first_index;
                    CRF_WS_INDEX_Y: word_rd_data = st.second_index;
                    default: word_rd_data = st.primary_register_set.hl;
                endcase
            end
            default:
            begin
                if (word_kind == CRF_WS_ACC_PAIR)
                    word_rd_data = {st.primary_register_set.acc, st.primary_register_set.flags};
                else
                    word_rd_data = st.stack_top_pointer;
            end
        endcase
    end

    // high and low halves for the H and L suffix forms
    assign word_rd_high = word_rd_data[15:8];
    assign word_rd_low = word_rd_data[7:0];

    // next state: exchange, register writes, flags, counters, addresses, apb
    always_comb
    begin
        logic [7:0] f;
        logic ovf;
        logic sa;
        logic sb;
        next_st = st;
        f = st.primary_register_set.flags;
        ovf = 1'b0;
        sa = alu.word_op ? alu_op_a_hi[7] : alu_op_a[7];
        sb = alu.word_op ? alu_op_b_hi[7] : alu_op_b[7];

        // wholesale swap is the only path to the alternate set
        if (exchange_sets)
        begin
            next_st.primary_register_set = st.alternate_register_set;
            next_st.alternate_register_set = st.primary_register_set;
        end

        // byte writes land in the primary set only
        if (byte_wr_en)
        begin
            case (byte_wr_sel)
                CRF_SEL_B: next_st.primary_register_set.bc[15:8] = byte_wr_data;
                CRF_SEL_C: next_st.primary_register_set.bc[7:0] = byte_wr_data;
                CRF_SEL_D: next_st.primary_register_set.de[15:8] = byte_wr_data;
                CRF_SEL_E: next_st.primary_register_set.de[7:0] = byte_wr_data;
                CRF_SEL_H: next_st.primary_register_set.hl[15:8] = byte_wr_data;
                CRF_SEL_L: next_st.primary_register_set.hl[7:0] = byte_wr_data;
                CRF_SEL_A: next_st.primary_register_set.acc = byte_wr_data;
                default: ;
            endcase
        end

        // word writes, same decode as the read side
        if (word_wr_en)
        begin
            case (word_wr_sel)
                2'h0: next_st.primary_register_set.bc = word_wr_data;
                2'h1: next_st.primary_register_set.de = word_wr_data;
                2'h2:
                begin
                    if (word_kind == CRF_WS_INDEX_X)
                        next_st.first_index = word_wr_data;
                    else if (word_kind == CRF_WS_INDEX_Y)
                        next_st.second_index = word_wr_data;
                    else
                        next_st.primary_register_set.hl = word_wr_data;
                end
                default:
                begin
                    if (word_kind == CRF_WS_ACC_PAIR)
                    begin
                        next_st.primary_register_set.acc = word_wr_data[15:8];
                        next_st.primary_register_set.flags = word_wr_data[7:0];
                    end
                    else
                        next_st.stack_top_pointer = word_wr_data;
                end
            endcase
        end

        // flag update from an alu result; wins over a pair write of the flags
        if (flag_upd)
        begin
            // signed overflow: like-signed add, or unlike-signed sub, flips the sign
            if (alu.opclass == CRF_OP_ADD)
                ovf = (sa == sb) && (res_sign != sa);
            else
                ovf = (sa != sb) && (res_sign != sa);
            if (alu.opclass != CRF_OP_SHIFT)
            begin
                f[CRF_FLAG_SIGN] = res_sign;
                f[CRF_FLAG_ZERO] = alu.word_op ? (alu.sum[15:0] == 16'h0000)
                    : (alu.sum[7:0] == 8'h00);
                f[CRF_FLAG_HALF] = alu.half_carry;
            end
            case (alu.opclass)
                CRF_OP_LOGIC: f[CRF_FLAG_PV] = ~^alu.sum[7:0];
                CRF_OP_ADD, CRF_OP_SUB:
                begin
                    f[CRF_FLAG_PV] = ovf;
                    f[CRF_FLAG_SUB] = (alu.opclass == CRF_OP_SUB);
                    f[CRF_FLAG_CARRY] = alu.word_op ? alu.sum[16] : alu.sum[8];
                end
                default: f[CRF_FLAG_CARRY] = alu.shift_carry;
            endcase
            next_st.primary_register_set.flags = f;
        end

        // opcode fetch: bump the low seven counter bits and step the pc
        if (opcode_fetch_indicator)
        begin
            next_st.fetch_count[6:0] = st.fetch_count[6:0] + 7'h01;
            next_st.instruction_address_counter =
                st.instruction_address_counter + fetch_step;
        end

        // relative branch and jump load of the pc
        if (pc_load)
        begin
            if (amode == CRF_AM_RELATIVE)
                next_st.instruction_address_counter =
                    st.instruction_address_counter + disp_ext;
            else
                next_st.instruction_address_counter = {instr_byte1, instr_byte0};
        end

        // i/o address forms; strobe low for one cycle per request
        next_st.io_space_strobe_n = !io_req;
        if (io_req)
        begin
            case (io_form)
                CRF_IO_IMM_ACC:
                    next_st.io_addr = {st.primary_register_set.acc, instr_byte0};
                CRF_IO_B_C:
                    next_st.io_addr = {st.primary_register_set.bc[7:0],
                        st.primary_register_set.bc[15:8]};
                CRF_IO_IMM_ZERO: next_st.io_addr = {CRF_IO_HIGH_ZERO, instr_byte0};
                default:
                    next_st.io_addr = {CRF_IO_HIGH_ZERO, st.primary_register_set.bc[7:0]};
            endcase
        end

        // apb writes: debug path, applied last
        if (apb_wr)
        begin
            if (paddr == CRF_OFF_FLAGS)
                next_st.primary_register_set.flags = pwdata[7:0];
            else if (paddr == CRF_OFF_ACC)
                next_st.primary_register_set.acc = pwdata[7:0];
            else if (paddr == CRF_OFF_VPAGE)
                next_st.vector_page = pwdata[7:0];
            else if (paddr == CRF_OFF_PC)
                next_st.instruction_address_counter = pwdata[15:0];
            else if (paddr == CRF_OFF_SP)
                next_st.stack_top_pointer = pwdata[15:0];
        end

        // apb read data captured in setup so it stands through the access phase
        if (apb_rd)
        begin
            if (paddr == CRF_OFF_FLAGS)
                next_st.prdata = {24'h000000, st.primary_register_set.flags};
            else if (paddr == CRF_OFF_ACC)
                next_st.prdata = {24'h000000, st.primary_register_set.acc};
            else if (paddr == CRF_OFF_VPAGE)
                next_st.prdata = {24'h000000, st.vector_page};
            else if (paddr == CRF_OFF_FETCH)
                next_st.prdata = {24'h000000, st.fetch_count};
            else if (paddr == CRF_OFF_PC)
                next_st.prdata = {16'h0000, st.instruction_address_counter};
            else if (paddr == CRF_OFF_SP)
                next_st.prdata = {16'h0000, st.stack_top_pointer};
            else if (paddr == CRF_OFF_CTRL)
                next_st.prdata = {16'h0000, st.first_index};
            else
                next_st.prdata = 32'h00000000;  // unmapped reads return zero
        end
    end

    // state register; every field takes a constant under reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= '0;
            st.vector_page <= CRF_RST_BYTE;
            st.fetch_count <= CRF_RST_BYTE;
            st.stack_top_pointer <= CRF_RST_WORD;
            st.instruction_address_counter <= CRF_RST_WORD;
            st.io_space_strobe_n <= 1'b1;
        end
        else
            st <= next_st;
    end

    // operand address by mode
    always_comb
    begin
        case (amode)
            CRF_AM_INDIRECT:
            begin
                case (indirect_sel)
                    2'h0: operand_addr = st.primary_register_set.bc;
                    2'h1: operand_addr = st.primary_register_set.de;
                    default: operand_addr = st.primary_register_set.hl;
                endcase
            end
            CRF_AM_INDEXED: operand_addr = idx + disp_ext;
            CRF_AM_RELATIVE: operand_addr = st.instruction_address_counter + disp_ext;
            default: operand_addr = {instr_byte1, instr_byte0};
        endcase
    end

    // immediate operand of one or two bytes
    assign immediate_data = word_immediate ? {instr_byte1, instr_byte0}
        : {8'h00, instr_byte0};

    // vector page forms the table high byte
    assign vector_table_addr = {st.vector_page, vector_low};

    assign prdata = st.prdata;
    assign io_addr = st.io_addr;
    assign io_space_strobe_n = st.io_space_strobe_n;
    assign flags_now = st.primary_register_set.flags;

    // fetch counter: low seven bits step by one per fetch
    fetch_count_a: assert property (@(posedge pclk) disable iff (!presetn)
        opcode_fetch_indicator && !(apb_wr) |=> st.fetch_count[6:0]
        == $past(st.fetch_count[6:0]) + 7'h01) else $error("fetch counter did not step");

    // zero flag follows a zero byte result
    zero_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        flag_upd && !alu.word_op && alu.opclass != CRF_OP_SHIFT && alu.sum[7:0] == 8'h00
        && !(apb_wr && paddr == CRF_OFF_FLAGS) && !exchange_sets
        |=> flags_now[CRF_FLAG_ZERO]) else $error("zero flag not set");

    // i/o strobe pulses the cycle after a request
    io_strobe_a: assert property (@(posedge pclk) disable iff (!presetn)
        io_req |=> !io_space_strobe_n) else $error("io strobe missing");

    // internal forms drive zero on the high address byte
    io_high_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        io_req && (io_form == CRF_IO_IMM_ZERO || io_form == CRF_IO_C_ZERO)
        |=> io_addr[15:8] == 8'h00) else $error("io high byte not zero");

    // double exchange restores the accumulator
    swap_back_a: assert property (@(posedge pclk) disable iff (!presetn)
        exchange_sets && !byte_wr_en && !word_wr_en && !flag_upd && !apb_wr
        ##1 exchange_sets && !byte_wr_en && !word_wr_en && !flag_upd && !apb_wr
        |=> st.primary_register_set.acc == $past(st.primary_register_set.acc, 2))
        else $error("exchange not wholesale");

    // indexed address adds the signed displacement
    index_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
        amode == CRF_AM_INDEXED |-> operand_addr == idx + {{8{instr_byte0[7]}}, instr_byte0})
        else $error("indexed address wrong");

    // code 110 reads nothing
    byte_none_a: assert property (@(posedge pclk) disable iff (!presetn)
        byte_rd_sel == CRF_SEL_NONE |-> byte_rd_data == 8'h00)
        else $error("code 110 selected a register");

    // subtract flag after a sub op
    sub_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        flag_upd && alu.opclass == CRF_OP_SUB && !exchange_sets
        && !(apb_wr && paddr == CRF_OFF_FLAGS) |=> flags_now[CRF_FLAG_SUB])
        else $error("subtract flag not set");

endmodule

/* File: crf_exec_model.sv */
// Purpose: stand-in for decode logic issuing opcode fetch cycles
// Assumes: one fetch pulse every second cycle, like back-to-back opcodes
// Notes: a gap cycle between fetches keeps each pulse distinct
`timescale 1ns/1ps

module crf_exec_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic go,
    input wire logic [3:0] burst,
    output logic opcode_fetch_indicator
);
    logic [4:0] left;

    // go loads twice the burst; even counts give one pulse each
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            left <= '0;
            opcode_fetch_indicator <= 1'b0;
        end
        else
        begin
            opcode_fetch_indicator <= (left != 5'h00) && !left[0];
            if (left != 5'h00)
                left <= left - 5'h01;
            if (go)
                left <= {burst, 1'b0};
        end
    end
endmodule

/* File: crf_pkg.sv */
// Purpose: shared constants and types for the cpu register file block
// Assumes: 8-bit core, one clock domain, apb register access
// Notes: holds reset values, select codes, register offsets and the state struct
package crf_pkg;

    // apb register offsets (byte addresses)
    localparam logic [7:0] CRF_OFF_FLAGS = 8'h00;
    localparam logic [7:0] CRF_OFF_ACC = 8'h04;
    localparam logic [7:0] CRF_OFF_VPAGE = 8'h08;
    localparam logic [7:0] CRF_OFF_FETCH = 8'h0c;
    localparam logic [7:0] CRF_OFF_PC = 8'h10;
    localparam logic [7:0] CRF_OFF_SP = 8'h14;
    localparam logic [7:0] CRF_OFF_CTRL = 8'h18;

    // reset values
    localparam logic [7:0] CRF_RST_BYTE = 8'h00;
    localparam logic [15:0] CRF_RST_WORD = 16'h0000;
    localparam logic [7:0] CRF_IO_HIGH_ZERO = 8'h00;

    // flag bit positions
    localparam int CRF_FLAG_SIGN = 7;
    localparam int CRF_FLAG_ZERO = 6;
    localparam int CRF_FLAG_HALF = 4;
    localparam int CRF_FLAG_PV = 2;
    localparam int CRF_FLAG_SUB = 1;
    localparam int CRF_FLAG_CARRY = 0;

    // byte select codes
    localparam logic [2:0] CRF_SEL_B = 3'h0;
    localparam logic [2:0] CRF_SEL_C = 3'h1;
    localparam logic [2:0] CRF_SEL_D = 3'h2;
    localparam logic [2:0] CRF_SEL_E = 3'h3;
    localparam logic [2:0] CRF_SEL_H = 3'h4;
    localparam logic [2:0] CRF_SEL_L = 3'h5;
    localparam logic [2:0] CRF_SEL_NONE = 3'h6;
    localparam logic [2:0] CRF_SEL_A = 3'h7;

    // word select field flavours
    typedef enum logic [1:0] {CRF_WS_ACC_PAIR, CRF_WS_INDEX_X, CRF_WS_SP, CRF_WS_INDEX_Y}
        crf_wsel_e;

    // operand address modes
    typedef enum logic [2:0] {CRF_AM_INDIRECT, CRF_AM_INDEXED, CRF_AM_EXTENDED,
        CRF_AM_RELATIVE, CRF_AM_IMMED} crf_amode_e;

    // i/o address forms
    typedef enum logic [1:0] {CRF_IO_IMM_ACC, CRF_IO_B_C, CRF_IO_IMM_ZERO, CRF_IO_C_ZERO}
        crf_iofm_e;

    // alu operation classes that shape the flags
    typedef enum logic [1:0] {CRF_OP_ADD, CRF_OP_SUB, CRF_OP_LOGIC, CRF_OP_SHIFT}
        crf_opcl_e;

    // one general register set
    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] flags;
        logic [15:0] bc;
        logic [15:0] de;
        logic [15:0] hl;
    } crf_set_s;

    // full state of the block
    typedef struct packed {
        crf_set_s primary_register_set;
        crf_set_s alternate_register_set;
        logic [7:0] vector_page;
        logic [7:0] fetch_count;
        logic [15:0] first_index;
        logic [15:0] second_index;
        logic [15:0] stack_top_pointer;
        logic [15:0] instruction_address_counter;
        logic [31:0] prdata;
        logic [15:0] io_addr;
        logic io_space_strobe_n;
    } crf_state_s;

    // flag result reported by the alu
    typedef struct packed {
        logic [16:0] sum;      // result; carry out in bit 16 for word ops, bit 8 for byte ops
        logic half_carry;
        logic word_op;
        crf_opcl_e opclass;
        logic shift_carry;
    } crf_alu_s;

endpackage

/* File: tb_top.sv */
// Purpose: self-checking bench for the cpu register file
// Assumes: pready answers at once but is still waited for
// Notes: use_second_index is left tied; relative branch and word immediates are driven in t_regs
`timescale 1ns/1ps

module tb_top
    import crf_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
    logic exchange_sets = 0, byte_wr_en = 0, word_wr_en = 0, flag_upd = 0, io_req = 0;
    logic word_immediate = 0, pc_load = 0, use_second_index = 0;
    logic [7:0] paddr = 0, byte_wr_data = 0, alu_op_a = 0, alu_op_b = 0, alu_op_a_hi = 0;
    logic [7:0] alu_op_b_hi = 0, instr_byte0 = 0, instr_byte1 = 0, vector_low = 0;
    logic [2:0] byte_rd_sel = 0, byte_wr_sel = 0;
    logic [1:0] word_rd_sel = 0, word_wr_sel = 0, indirect_sel = 0;
    logic [3:0] burst = 4'h5;
    logic [15:0] fetch_step = 16'h0003, word_wr_data = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    crf_wsel_e word_kind = CRF_WS_ACC_PAIR;
    crf_amode_e amode = CRF_AM_INDIRECT;
    crf_iofm_e io_form = CRF_IO_IMM_ACC;
    crf_alu_s alu = '0;
    logic pready, pslverr, opcode_fetch_indicator, io_space_strobe_n;
    logic [7:0] byte_rd_data, word_rd_high, word_rd_low, flags_now;
    logic [15:0] word_rd_data, operand_addr, immediate_data, io_addr, vector_table_addr;
    int mismatches = 0, compares = 0;

    crf_core i_crf_core (.*);
    crf_exec_model i_crf_exec_model (.*);

    // 25 mhz clock
    always #20 pclk = ~pclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        {psel, penable} <= 2'b00;
    endtask

    task automatic bwr(input logic [2:0] s, input logic [7:0] d);
        @(posedge pclk);
        {byte_wr_en, byte_wr_sel, byte_wr_data} <= {1'b1, s, d};
        @(posedge pclk);
        byte_wr_en <= 1'b0;
    endtask

    task automatic xchg();
        @(posedge pclk);
        exchange_sets <= 1'b1;
        @(posedge pclk);
        exchange_sets <= 1'b0;
        byte_rd_sel <= CRF_SEL_A;
    endtask

    // only the documented flag bits are compared, bits 5 and 3 masked
    task automatic flg(input crf_alu_s v, input logic [7:0] a, input logic [7:0] b,
        input logic [7:0] m, input logic [7:0] e);
        @(posedge pclk);
        {flag_upd, alu, alu_op_a, alu_op_b} <= {1'b1, v, a, b};
        @(posedge pclk);
        flag_upd <= 1'b0;
        #1 chk({24'h0, flags_now & m}, {24'h0, e});
    endtask

    task automatic t_reset_fetch();
        for (int i = 2; i < 6; i++)
        begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk(rd, 32'h0);
        end
        @(posedge pclk);
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        repeat (14) @(posedge pclk);
        apb(1'b0, CRF_OFF_FETCH, 32'h0);
        chk(rd, 32'h5);
        apb(1'b0, CRF_OFF_PC, 32'h0);
        chk(rd, 32'hf);
        apb(1'b0, 8'h1c, 32'h0);
        chk(rd, 32'h0);
    endtask

    task automatic t_regs();
        for (int i = 0; i < 8; i++)
            bwr(3'(i), 8'h10 + 8'(i));
        for (int i = 0; i < 8; i++)
        begin
            @(posedge pclk);
            byte_rd_sel <= 3'(i);
            #1 chk(byte_rd_data, (i == 6) ? 32'h0 : 32'h10 + i);
        end
        @(posedge pclk);
        {word_wr_en, word_wr_sel, word_wr_data} <= {1'b1, 2'h2, 16'h1000};
        word_kind <= CRF_WS_INDEX_X;
        @(posedge pclk);
        word_wr_en <= 1'b0;
        #1 chk(word_rd_data, 16'h1011);
        @(posedge pclk);
        {word_rd_sel, instr_byte0} <= {2'h2, 8'hfe};
        amode <= CRF_AM_INDEXED;
        #1 chk(word_rd_data, 16'h1000);
        chk(operand_addr, 16'h0ffe);
        @(posedge pclk);
        word_kind <= CRF_WS_ACC_PAIR;
        word_rd_sel <= 2'h0;
        amode <= CRF_AM_INDIRECT;
        instr_byte1 <= 8'h12;
        #1 chk({word_rd_high, word_rd_low}, 16'h1011);
        chk(operand_addr, 16'h1011);
        @(posedge pclk);
        amode <= CRF_AM_EXTENDED;
        #1 chk(operand_addr, 16'h12fe);
        @(posedge pclk);
        {word_wr_en, word_wr_sel, word_wr_data} <= {1'b1, 2'h3, 16'h2468};
        word_kind <= CRF_WS_SP;
        word_immediate <= 1'b1;
        #1 chk(immediate_data, 16'h12fe);
        @(posedge pclk);
        {word_wr_en, word_rd_sel} <= {1'b0, 2'h3};
        word_kind <= CRF_WS_INDEX_Y;
        amode <= CRF_AM_RELATIVE;
        #1 chk(word_rd_data, 16'h2468);
        chk(operand_addr, 16'h000d);
        @(posedge pclk);
        {pc_load, word_immediate} <= 2'b10;
        #1 chk(immediate_data, 16'h00fe);
        @(posedge pclk);
        pc_load <= 1'b0;
        apb(1'b0, CRF_OFF_SP, 32'h0);
        chk(rd, 32'h2468);
        apb(1'b0, CRF_OFF_PC, 32'h0);
        chk(rd, 32'hd);
    endtask

    task automatic t_io_vec();
        logic [15:0] e [4] = '{16'h179a, 16'h1110, 16'h009a, 16'h0011};
        for (int i = 0; i < 4; i++)
        begin
            @(posedge pclk);
            {io_req, instr_byte0} <= {1'b1, 8'h9a};
            io_form <= crf_iofm_e'(i);
            @(posedge pclk);
            io_req <= 1'b0;
            #1 chk(io_addr, e[i]);
            chk(io_space_strobe_n, 1'b0);
            @(posedge pclk);
            #1 chk(io_space_strobe_n, 1'b1);
        end
        apb(1'b1, CRF_OFF_VPAGE, 32'h3c);
        vector_low <= 8'h10;
        @(posedge pclk);
        #1 chk(vector_table_addr, 16'h3c10);
        xchg();
        #1 chk(byte_rd_data, 8'h00);
        xchg();
        #1 chk(byte_rd_data, 8'h17);
        @(posedge pclk);
        exchange_sets <= 1'b1;
        repeat (2) @(posedge pclk);
        exchange_sets <= 1'b0;
        #1 chk(byte_rd_data, 8'h17);
    endtask

    task automatic t_flags();
        flg('{17'h00100, 1'b0, 1'b0, CRF_OP_ADD, 1'b0}, 8'h80, 8'h80, 8'hd7, 8'h45);
        flg('{17'h001ff, 1'b1, 1'b0, CRF_OP_SUB, 1'b0}, 8'h00, 8'h01, 8'hd7, 8'h93);
        flg('{17'h00003, 1'b0, 1'b0, CRF_OP_LOGIC, 1'b0}, 8'h03, 8'h07, 8'h04, 8'h04);
    endtask

    task automatic summarize();
        if (mismatches == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // reset held six cycles, then the scenarios in turn
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_fetch();
        t_regs();
        t_io_vec();
        t_flags();
        summarize();
    end

    // a hang costs a mismatch; all tests need well under 400 cycles
    initial
    begin
        repeat (3000) @(posedge pclk);
        mismatches++;
        summarize();
    end
endmodule
